// [bck_cfg.svh]
// Purpose: Constants for the border and crop key stage: register indices, defaults, limits and scaling.
// Assumes: Edge positions are signed counts of 0.125 raster units, origin at the raster centre.
// Notes:   Border softness, level and opacity settings are held as counts of their alignment step; crop softness in hundredths.
//
// Behaviour
// - Crop first, border follows cropped edges.
// - Stage sits before any geometric transform.
// - Outer border edge on crop, inner moves.
// - Border always on, zero width by default.
// - Positions relative to raster centre origin.
// - Border edge defaults per SD/HD, .125 steps.
// - Crop defaults raster edges, bounded range.
// - Border softness on inner edge, 12.5 steps.
// - Softened zero-width border still visible.
// - Cropping shapes key, not video pixels.
// - Dual video fills crop gap with border.
// - Video+key mode uses one crop softness.
// - Video+key mode never borders key channel.
// - Per-edge crop softness, -1.00 to 100.00.
// - Luminance level 0 black to 100 white.
// - Saturation 0 none to 100 full.
// - Hue in 45 degree steps, within 720.
// - Opacity blends border colour, default 0.
`ifndef BCK_CFG_SVH
`define BCK_CFG_SVH

// Register indices on the plain register port.
`define BCK_REG_CTRL        5'h00
`define BCK_REG_CROP_L      5'h01
`define BCK_REG_CROP_R      5'h02
`define BCK_REG_CROP_T      5'h03
`define BCK_REG_CROP_B      5'h04
`define BCK_REG_BORD_L      5'h05
`define BCK_REG_BORD_R      5'h06
`define BCK_REG_BORD_T      5'h07
`define BCK_REG_BORD_B      5'h08
`define BCK_REG_CSOFT_L     5'h09
`define BCK_REG_CSOFT_R     5'h0A
`define BCK_REG_CSOFT_T     5'h0B
`define BCK_REG_CSOFT_B     5'h0C
`define BCK_REG_BSOFT       5'h0D
`define BCK_REG_LUM         5'h0E
`define BCK_REG_SAT         5'h0F
`define BCK_REG_HUE         5'h10
`define BCK_REG_OPACITY     5'h11
`define BCK_REG_STATUS      5'h12

// Control register fields.
`define BCK_CTRL_HD_BIT     0
`define BCK_CTRL_DUAL_BIT   1
`define BCK_CTRL_LOAD_BIT   2

// Raster edges in 0.125 units: SD 0.5/0.375, HD 8.0/4.5.
`define BCK_SD_HEDGE        16'sh0004
`define BCK_SD_VEDGE        16'sh0003
`define BCK_HD_HEDGE        16'sh0040
`define BCK_HD_VEDGE        16'sh0024

// Position limits in 0.125 units: SD 99.999, HD 1599.9984 and 1199.9987.
`define BCK_SD_LIMIT        16'sh031F
`define BCK_HD_HLIMIT       16'sh31FF
`define BCK_HD_VLIMIT       16'sh257F

// Crop softness in hundredths: -1.00 to 100.00.
`define BCK_CSOFT_MIN       16'shFF9C
`define BCK_CSOFT_MAX       16'sh2710
`define BCK_CSOFT_SHIFT     3

// Step counts: 100.0 in 12.5 steps is 8; hue 720 in 45 steps is 16.
`define BCK_STEP_MAX        16'sh0008
`define BCK_HUE_LIMIT       16'sh0010
`define BCK_BSOFT_UNITS     16'h0010
`define BCK_CHROMA_FULL     8'h70
`define BCK_CHROMA_DIAG     8'h4F

`endif

// [bck_pkg.sv]
// Purpose: Types shared by the border and crop key stage.
// Assumes: Constants come from bck_cfg.svh.
// Notes:   The register set is one packed struct so it can be reset and copied whole.
package bck_pkg;

  typedef enum logic {BCK_MODE_VKEY, BCK_MODE_DUAL} bck_mode_type;

  typedef struct packed {
    logic                    hd;
    bck_mode_type            mode;
    logic signed [3:0][15:0] crop;
    logic signed [3:0][15:0] bord;
    logic signed [3:0][15:0] csoft;
    logic [3:0]              bsoft;
    logic [3:0]              lum;
    logic [3:0]              sat;
    logic signed [5:0]       hue;
    logic [3:0]              opacity;
  } bck_regs_type;

endpackage

// [bck_top.sv]
// Purpose: Border and crop key stage with its output FIFO, for one video channel.
// Assumes: Each pixel arrives with its source position; the transform stage lies downstream.
// Notes:   Edge index 0..3 is left, right, top, bottom; top is positive vertically.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "bck_cfg.svh"

module bck_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  // Filling side.
  input  wire logic                       in_valid_in,
  output      logic                       in_ready_out,
  input  wire logic [WIDTH-1:0]           in_data_in,
  // Draining side.
  output      logic                       out_valid_out,
  input  wire logic                       out_ready_in,
  output      logic [WIDTH-1:0]           out_data_out,
  output      logic [$clog2(DEPTH):0]     level_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } bck_fifo_state_type;

  bck_fifo_state_type s_ff;
  bck_fifo_state_type nxt_s;
  logic               push;
  logic               pop;

  assign in_ready_out  = (s_ff.count != (AW+1)'(DEPTH));
  assign out_valid_out = (s_ff.count != '0);
  assign out_data_out  = s_ff.mem[s_ff.rd_ptr];
  assign level_out     = s_ff.count;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wr_ptr] = in_data_in;
      nxt_s.wr_ptr = (s_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : s_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_s.rd_ptr = (s_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : s_ff.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      nxt_s.count = s_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_s.count = s_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

module bck_top #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input  wire logic                 MCLK_IN,
  input  wire logic                 RST_N_IN,
  // Register port.
  input  wire logic [4:0]           REG_ADDR_IN,
  input  wire logic [15:0]          REG_WDATA_IN,
  input  wire logic                 REG_WR_IN,
  input  wire logic                 REG_RD_IN,
  output      logic [15:0]          REG_RDATA_OUT,
  // Incoming video and key, with source position.
  input  wire logic                 PIX_VALID_IN,
  output      logic                 PIX_READY_OUT,
  input  wire logic signed [15:0]   PIX_HPOS_IN,
  input  wire logic signed [15:0]   PIX_VPOS_IN,
  input  wire logic [7:0]           PIX_LUMA_IN,
  input  wire logic [7:0]           PIX_CB_IN,
  input  wire logic [7:0]           PIX_CR_IN,
  input  wire logic [7:0]           PIX_KEY_IN,
  // Outgoing video and key toward the transform stage.
  output      logic                 OUT_VALID_OUT,
  input  wire logic                 OUT_READY_IN,
  output      logic [7:0]           OUT_LUMA_OUT,
  output      logic [7:0]           OUT_CB_OUT,
  output      logic [7:0]           OUT_CR_OUT,
  output      logic [7:0]           OUT_KEY_OUT
);
  import bck_pkg::*;

  typedef struct packed {
    bck_regs_type regs;
    logic [15:0]  rdata;
  } bck_state_type;

  bck_state_type      s_ff;
  bck_state_type      nxt_s;
  logic [4:0]         fifo_level;
  logic [31:0]        fifo_out;
  logic [7:0]         new_luma;
  logic [7:0]         new_cb;
  logic [7:0]         new_cr;
  logic [7:0]         new_key;

  // mode defaults: border and crop edges both sit on the raster edge.
  function automatic bck_regs_type defaults(input logic hd, input bck_mode_type mode);
    bck_regs_type r;
    logic signed [15:0] he;
    logic signed [15:0] ve;
    r = '0;
    he = hd ? `BCK_HD_HEDGE : `BCK_SD_HEDGE;
    ve = hd ? `BCK_HD_VEDGE : `BCK_SD_VEDGE;
    r.hd = hd;
    r.mode = mode;
    r.crop = {-ve, ve, he, -he};
    r.bord = {-ve, ve, he, -he};
    return r;
  endfunction

  function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                               input logic signed [15:0] lo,
                                               input logic signed [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // monotonic ramp of width w, clamped to 0..255.
  function automatic logic [7:0] ramp(input logic signed [16:0] d, input logic [15:0] w);
    logic [24:0] q;
    q = '0;
    if (d <= 0) begin
      return 8'h00;
    end else if (w == '0 || d >= $signed({1'b0, w})) begin
      return 8'hFF;
    end
    q = (25'(d) * 25'd255) / 25'(w);
    return q[7:0];
  endfunction

  function automatic logic [7:0] min4(input logic [3:0][7:0] v);
    logic [7:0] m;
    m = v[0];
    for (int i = 1; i < 4; i++) begin
      if (v[i] < m) begin
        m = v[i];
      end
    end
    return m;
  endfunction

  function automatic logic [7:0] blend(input logic [7:0] a, input logic [7:0] b, input logic [7:0] wb);
    logic [15:0] acc;
    acc = 16'(a) * 16'(8'hFF - wb) + 16'(b) * 16'(wb);
    // The end points are exact, so untouched video and an opaque border keep their codes.
    if (wb == 8'h00) begin
      return a;
    end else if (wb == 8'hFF) begin
      return b;
    end
    return acc[15:8] + 8'(acc[15:8] == 8'hFF ? 0 : acc[7]);
  endfunction

  // hue sector to chroma direction; sector 0 blue, 2 red.
  function automatic logic signed [8:0] hue_dir(input logic [2:0] sec, input logic want_cr);
    logic signed [8:0] f;
    logic signed [8:0] g;
    f = 9'($signed({1'b0, `BCK_CHROMA_FULL}));
    g = 9'($signed({1'b0, `BCK_CHROMA_DIAG}));
    unique case (sec)
      3'h0: return want_cr ? 9'sh000 : f;
      3'h1: return g;
      3'h2: return want_cr ? f : 9'sh000;
      3'h3: return want_cr ? g : -g;
      3'h4: return want_cr ? 9'sh000 : -f;
      3'h5: return -g;
      3'h6: return want_cr ? -f : 9'sh000;
      3'h7: return want_cr ? -g : g;
    endcase
  endfunction

  // Register port: writes take effect next edge, read data stand one cycle.
  always_comb begin
    logic signed [15:0] w;
    logic signed [15:0] hlim;
    logic signed [15:0] vlim;
    logic signed [15:0] lim;
    logic [1:0]         e;
    w = $signed(REG_WDATA_IN);
    hlim = s_ff.regs.hd ? `BCK_HD_HLIMIT : `BCK_SD_LIMIT;
    vlim = s_ff.regs.hd ? `BCK_HD_VLIMIT : `BCK_SD_LIMIT;
    e = REG_ADDR_IN[1:0] - 2'h1;
    lim = e[1] ? vlim : hlim;
    nxt_s = s_ff;
    nxt_s.rdata = '0;
    if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        `BCK_REG_CTRL: begin
          if (REG_WDATA_IN[`BCK_CTRL_LOAD_BIT]) begin
            nxt_s.regs = defaults(REG_WDATA_IN[`BCK_CTRL_HD_BIT],
                                  bck_mode_type'(REG_WDATA_IN[`BCK_CTRL_DUAL_BIT]));
          end else begin
            nxt_s.regs.hd = REG_WDATA_IN[`BCK_CTRL_HD_BIT];
            nxt_s.regs.mode = bck_mode_type'(REG_WDATA_IN[`BCK_CTRL_DUAL_BIT]);
          end
        end
        `BCK_REG_CROP_L, `BCK_REG_CROP_R, `BCK_REG_CROP_T, `BCK_REG_CROP_B:
          nxt_s.regs.crop[e] = clamp(w, -lim, lim);
        // only the inner border edge is programmable.
        `BCK_REG_BORD_L, `BCK_REG_BORD_R, `BCK_REG_BORD_T, `BCK_REG_BORD_B:
          nxt_s.regs.bord[e] = clamp(w, -lim, lim);
        `BCK_REG_CSOFT_L, `BCK_REG_CSOFT_R, `BCK_REG_CSOFT_T, `BCK_REG_CSOFT_B:
          nxt_s.regs.csoft[REG_ADDR_IN[1:0] - 2'h1] = clamp(w, `BCK_CSOFT_MIN, `BCK_CSOFT_MAX);
        `BCK_REG_BSOFT:   nxt_s.regs.bsoft = 4'(clamp(w, 16'sh0000, `BCK_STEP_MAX));
        `BCK_REG_LUM:     nxt_s.regs.lum = 4'(clamp(w, 16'sh0000, `BCK_STEP_MAX));
        `BCK_REG_SAT:     nxt_s.regs.sat = 4'(clamp(w, 16'sh0000, `BCK_STEP_MAX));
        `BCK_REG_HUE:     nxt_s.regs.hue = 6'(clamp(w, -`BCK_HUE_LIMIT, `BCK_HUE_LIMIT));
        `BCK_REG_OPACITY: nxt_s.regs.opacity = 4'(clamp(w, 16'sh0000, `BCK_STEP_MAX));
        default: ;
      endcase
    end
    if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        `BCK_REG_CTRL:    nxt_s.rdata = {14'h0000, s_ff.regs.mode, s_ff.regs.hd};
        `BCK_REG_CROP_L, `BCK_REG_CROP_R, `BCK_REG_CROP_T, `BCK_REG_CROP_B:
          nxt_s.rdata = s_ff.regs.crop[e];
        `BCK_REG_BORD_L, `BCK_REG_BORD_R, `BCK_REG_BORD_T, `BCK_REG_BORD_B:
          nxt_s.rdata = s_ff.regs.bord[e];
        `BCK_REG_CSOFT_L, `BCK_REG_CSOFT_R, `BCK_REG_CSOFT_T, `BCK_REG_CSOFT_B:
          nxt_s.rdata = s_ff.regs.csoft[REG_ADDR_IN[1:0] - 2'h1];
        `BCK_REG_BSOFT:   nxt_s.rdata = {12'h000, s_ff.regs.bsoft};
        `BCK_REG_LUM:     nxt_s.rdata = {12'h000, s_ff.regs.lum};
        `BCK_REG_SAT:     nxt_s.rdata = {12'h000, s_ff.regs.sat};
        `BCK_REG_HUE:     nxt_s.rdata = 16'(s_ff.regs.hue);
        `BCK_REG_OPACITY: nxt_s.rdata = {12'h000, s_ff.regs.opacity};
        `BCK_REG_STATUS:  nxt_s.rdata = {11'h000, fifo_level};
        default:          nxt_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      s_ff.regs <= defaults(1'b0, BCK_MODE_VKEY);
      s_ff.rdata <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign REG_RDATA_OUT = s_ff.rdata;

  // pixel path works on source positions, before any transform.
  always_comb begin
    logic signed [16:0] x;
    logic signed [16:0] y;
    logic [3:0][16:0]   dcrop;
    logic [3:0][16:0]   dbord;
    logic [3:0][7:0]    kcrop;
    logic [3:0][7:0]    kbord;
    logic [15:0]        cw;
    logic [15:0]        bw;
    logic [7:0]         crop_key;
    logic [7:0]         inner;
    logic [7:0]         weight;
    logic [11:0]        wacc;
    logic [7:0]         col_y;
    logic [7:0]         col_cb;
    logic [7:0]         col_cr;
    logic signed [12:0] cc;
    logic signed [15:0] he;
    logic signed [15:0] ve;
    logic               outside;
    x = 17'(PIX_HPOS_IN);
    y = 17'(PIX_VPOS_IN);
    dcrop = '0;
    dbord = '0;
    kcrop = '0;
    kbord = '0;
    cw = '0;
    bw = '0;
    crop_key = '0;
    inner = '0;
    weight = '0;
    wacc = '0;
    col_y = '0;
    col_cb = '0;
    col_cr = '0;
    cc = '0;
    he = '0;
    ve = '0;
    outside = 1'b0;
    dcrop[0] = x - 17'($signed(s_ff.regs.crop[0]));
    dcrop[1] = 17'($signed(s_ff.regs.crop[1])) - x;
    dcrop[2] = 17'($signed(s_ff.regs.crop[2])) - y;
    dcrop[3] = y - 17'($signed(s_ff.regs.crop[3]));
    // border distances are measured inside the cropped area.
    dbord[0] = x - 17'($signed(s_ff.regs.bord[0]));
    dbord[1] = 17'($signed(s_ff.regs.bord[1])) - x;
    dbord[2] = 17'($signed(s_ff.regs.bord[2])) - y;
    dbord[3] = y - 17'($signed(s_ff.regs.bord[3]));
    // softness widens only the inner border edge.
    bw = 16'(s_ff.regs.bsoft) * `BCK_BSOFT_UNITS;
    for (int i = 0; i < 4; i++) begin
      // video+key mode shares the left softness for all edges.
      cw = (s_ff.regs.mode == BCK_MODE_VKEY) ? s_ff.regs.csoft[0] : s_ff.regs.csoft[i];
      // negative softness gives a hard edge.
      cw = cw[15] ? 16'h0000 : (cw >> `BCK_CSOFT_SHIFT);
      kcrop[i] = ramp($signed(dcrop[i]), cw);
      // a soft ramp shows border colour even at zero width.
      kbord[i] = ramp($signed(dbord[i]), bw);
    end
    crop_key = min4(kcrop);
    inner = min4(kbord);
    // chroma amplitude scales with saturation, hue sector.
    cc = 13'(hue_dir(s_ff.regs.hue[2:0], 1'b0)) * 13'(s_ff.regs.sat);
    col_cb = 8'(13'sh080 + (cc >>> 3));
    cc = 13'(hue_dir(s_ff.regs.hue[2:0], 1'b1)) * 13'(s_ff.regs.sat);
    col_cr = 8'(13'sh080 + (cc >>> 3));
    col_y = (s_ff.regs.lum == 4'h8) ? 8'hFF : {s_ff.regs.lum[2:0], 5'h00};
    wacc = 12'(8'hFF - inner) * 12'(s_ff.regs.opacity);
    weight = 8'(wacc >> 3);
    // dual video: gap beyond the image edge takes border colour.
    he = s_ff.regs.hd ? `BCK_HD_HEDGE : `BCK_SD_HEDGE;
    ve = s_ff.regs.hd ? `BCK_HD_VEDGE : `BCK_SD_VEDGE;
    outside = (PIX_HPOS_IN < -he) || (PIX_HPOS_IN > he) || (PIX_VPOS_IN < -ve) || (PIX_VPOS_IN > ve);
    if (s_ff.regs.mode == BCK_MODE_DUAL && outside) begin
      weight = 8'hFF;
    end
    // border is always applied to the video.
    new_luma = blend(PIX_LUMA_IN, col_y, weight);
    new_cb = blend(PIX_CB_IN, col_cb, weight);
    new_cr = blend(PIX_CR_IN, col_cr, weight);
    // crops act on the key only, key never gets the border.
    if (s_ff.regs.mode == BCK_MODE_VKEY) begin
      new_key = 8'((16'(PIX_KEY_IN) * 16'(crop_key)) >> 8);
    end else begin
      new_key = crop_key;
    end
  end

  bck_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (MCLK_IN),
    .rst_n_in      (RST_N_IN),
    .in_valid_in   (PIX_VALID_IN),
    .in_ready_out  (PIX_READY_OUT),
    .in_data_in    ({new_luma, new_cb, new_cr, new_key}),
    .out_valid_out (OUT_VALID_OUT),
    .out_ready_in  (OUT_READY_IN),
    .out_data_out  (fifo_out),
    .level_out     (fifo_level)
  );

  assign OUT_LUMA_OUT = fifo_out[31:24];
  assign OUT_CB_OUT   = fifo_out[23:16];
  assign OUT_CR_OUT   = fifo_out[15:8];
  assign OUT_KEY_OUT  = fifo_out[7:0];
endmodule

// [bck_checker.sv]
// Purpose: Concurrent checks on the ports of the border and crop key stage.
// Assumes: One clock, synchronous active-low reset, register indices as in bck_cfg.svh.
// Notes:   FIFO occupancy is rebuilt here from the two stream handshakes.
`timescale 1ns/10ps
module bck_checker #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input wire logic               MCLK_IN,
  input wire logic               RST_N_IN,
  // Register port.
  input wire logic [4:0]         REG_ADDR_IN,
  input wire logic [15:0]        REG_WDATA_IN,
  input wire logic               REG_WR_IN,
  input wire logic               REG_RD_IN,
  input wire logic [15:0]        REG_RDATA_OUT,
  // Incoming pixels.
  input wire logic               PIX_VALID_IN,
  input wire logic               PIX_READY_OUT,
  input wire logic signed [15:0] PIX_HPOS_IN,
  input wire logic signed [15:0] PIX_VPOS_IN,
  input wire logic [7:0]         PIX_LUMA_IN,
  input wire logic [7:0]         PIX_CB_IN,
  input wire logic [7:0]         PIX_CR_IN,
  input wire logic [7:0]         PIX_KEY_IN,
  // Outgoing pixels.
  input wire logic               OUT_VALID_OUT,
  input wire logic               OUT_READY_IN,
  input wire logic [7:0]         OUT_LUMA_OUT,
  input wire logic [7:0]         OUT_CB_OUT,
  input wire logic [7:0]         OUT_CR_OUT,
  input wire logic [7:0]         OUT_KEY_OUT
);
  import bck_pkg::*;
  logic [7:0] occ_ff;
  logic [7:0] nxt_occ;
  always_comb begin
    nxt_occ = occ_ff + 8'(PIX_VALID_IN && PIX_READY_OUT) - 8'(OUT_VALID_OUT && OUT_READY_IN);
  end
  always_ff @(posedge MCLK_IN) begin
    occ_ff <= RST_N_IN ? nxt_occ : 8'h00;
  end
  default clocking dc @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  ready_full_a: assert property (PIX_READY_OUT == (occ_ff < FIFO_DEPTH))
    else $error("Input ready disagrees with FIFO occupancy");
  valid_occ_a: assert property (OUT_VALID_OUT == (occ_ff != 8'h00))
    else $error("Output valid disagrees with FIFO occupancy");
  out_hold_a: assert property (OUT_VALID_OUT && !OUT_READY_IN |=> OUT_VALID_OUT
    && $stable({OUT_LUMA_OUT, OUT_CB_OUT, OUT_CR_OUT, OUT_KEY_OUT})) else $error("Stalled output word moved");
  rdata_idle_a: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 16'h0000)
    else $error("Read data not zero outside the read answer cycle");
  unmapped_rd_a: assert property (REG_RD_IN && REG_ADDR_IN > 5'h12 |=> REG_RDATA_OUT == 16'h0000)
    else $error("Unmapped index read non-zero");
  lum_range_a: assert property (REG_RD_IN && REG_ADDR_IN == 5'h0E |=> REG_RDATA_OUT <= 16'h0008)
    else $error("Luminance level above full scale");
  bsoft_range_a: assert property (REG_RD_IN && REG_ADDR_IN == 5'h0D |=> REG_RDATA_OUT <= 16'h0008)
    else $error("Border softness above full scale");
  hue_range_a: assert property (REG_RD_IN && REG_ADDR_IN == 5'h10 |=>
    $signed(REG_RDATA_OUT) >= -16 && $signed(REG_RDATA_OUT) <= 16) else $error("Hue outside 720 degrees");
  csoft_range_a: assert property (REG_RD_IN && REG_ADDR_IN inside {[5'h09:5'h0C]} |=>
    $signed(REG_RDATA_OUT) >= -100 && $signed(REG_RDATA_OUT) <= 10000) else $error("Crop softness out of range");
  lum_back_a: assert property (REG_WR_IN && REG_ADDR_IN == 5'h0E && REG_WDATA_IN <= 16'h0008
    ##2 REG_RD_IN && REG_ADDR_IN == 5'h0E |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 3))
    else $error("Luminance level not read back as written");
  full_c: cover property (!PIX_READY_OUT);
  stall_c: cover property (OUT_VALID_OUT && !OUT_READY_IN);
  lum_rd_c: cover property (REG_RD_IN && REG_ADDR_IN == 5'h0E);
endmodule

bind bck_top bck_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .PIX_VALID_IN(PIX_VALID_IN), .PIX_READY_OUT(PIX_READY_OUT),
  .PIX_HPOS_IN(PIX_HPOS_IN), .PIX_VPOS_IN(PIX_VPOS_IN), .PIX_LUMA_IN(PIX_LUMA_IN), .PIX_CB_IN(PIX_CB_IN),
  .PIX_CR_IN(PIX_CR_IN), .PIX_KEY_IN(PIX_KEY_IN), .OUT_VALID_OUT(OUT_VALID_OUT), .OUT_READY_IN(OUT_READY_IN),
  .OUT_LUMA_OUT(OUT_LUMA_OUT), .OUT_CB_OUT(OUT_CB_OUT), .OUT_CR_OUT(OUT_CR_OUT), .OUT_KEY_OUT(OUT_KEY_OUT));

// [bck_sink.sv]
// Purpose: Model of the downstream transform channel that takes finished pixels.
// Assumes: Ready changes only just after a rising edge.
// Notes:   Accepted words queue in got as luma, cb, cr, key for the bench.
`timescale 1ns/10ps
module bck_sink (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Stall request from the bench.
  input  wire logic        stall_in,
  // Stream from the stage.
  input  wire logic        valid_in,
  output      logic        ready_out,
  input  wire logic [31:0] data_in
);
  logic [31:0] got [$];
  initial begin
    ready_out = 1'b0;
  end
  always @(posedge clk_in) begin
    if (rst_n_in && valid_in && ready_out) begin
      got.push_back(data_in);
    end
    ready_out <= rst_n_in && !stall_in;
  end
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the border and crop key stage.
// Assumes: 10 MHz clock; register indices and scaling as in bck_cfg.svh.
// Notes:   Pixel words are luma, cb, cr, key; source cb 40 and cr 50 mark untouched video.
`timescale 1ns/10ps
module testbench;
  import bck_pkg::*;
  logic        MCLK_IN = 1'b0;
  logic        RST_N_IN = 1'b0;
  logic [4:0]  ad = 5'h00;
  logic [15:0] wd = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        pv = 1'b0;
  logic [63:0] pix = 64'h0;
  logic        stl = 1'b0;
  wire  [15:0] rdat;
  wire         rdy;
  wire         ov;
  wire         ordy;
  wire  [31:0] ow;
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  bck_top #(.FIFO_DEPTH(16)) u_dut (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .REG_ADDR_IN(ad),
    .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .PIX_VALID_IN(pv),
    .PIX_READY_OUT(rdy), .PIX_HPOS_IN(pix[63:48]), .PIX_VPOS_IN(pix[47:32]), .PIX_LUMA_IN(pix[31:24]),
    .PIX_CB_IN(pix[23:16]), .PIX_CR_IN(pix[15:8]), .PIX_KEY_IN(pix[7:0]), .OUT_VALID_OUT(ov),
    .OUT_READY_IN(ordy), .OUT_LUMA_OUT(ow[31:24]), .OUT_CB_OUT(ow[23:16]), .OUT_CR_OUT(ow[15:8]),
    .OUT_KEY_OUT(ow[7:0]));
  bck_sink u_sink (.clk_in(MCLK_IN), .rst_n_in(RST_N_IN), .stall_in(stl), .valid_in(ov),
    .ready_out(ordy), .data_in(ow));
  initial begin
    forever #50 MCLK_IN = ~MCLK_IN;
  end
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge MCLK_IN) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic rchk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pchk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: pixel got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge MCLK_IN);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge MCLK_IN);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a, input logic [15:0] e);
    @(posedge MCLK_IN);
    ad <= a;
    rd <= 1'b1;
    @(posedge MCLK_IN);
    rd <= 1'b0;
    @(negedge MCLK_IN);
    rchk(rdat, e);
  endtask
  task automatic push(input logic [63:0] d);
    @(posedge MCLK_IN);
    pix <= d;
    pv <= 1'b1;
    do @(negedge MCLK_IN); while (rdy !== 1'b1);
    @(posedge MCLK_IN);
    pv <= 1'b0;
    pix <= ~d;
  endtask
  task automatic pget(input logic [63:0] d, output logic [31:0] w);
    push(d);
    w = 32'hXXXXXXXX;
    for (int i = 0; i < 8 && u_sink.got.size() == 0; i++) @(negedge MCLK_IN);
    if (u_sink.got.size() != 0) w = u_sink.got.pop_front();
  endtask
  task automatic pxl(input logic [63:0] d, input logic [31:0] e);
    logic [31:0] w;
    pget(d, w);
    pchk(w, e);
  endtask
  function automatic logic [63:0] px(input logic [15:0] h, input logic [7:0] l);
    return {h, 16'h0000, l, 24'h4050FF};
  endfunction
  initial begin
    logic [15:0] tb [4];
    logic [15:0] ct [10][3];
    logic [31:0] cl [6][4];
    logic [31:0] w;
    repeat (16) @(posedge MCLK_IN);
    RST_N_IN <= 1'b1;
    tb = '{16'hFFFC, 16'h0004, 16'h0003, 16'hFFFD};
    for (int i = 1; i < 9; i++) rreg(5'(i), tb[(i - 1) % 4]);
    for (int i = 9; i < 19; i++) rreg(5'(i), 16'h0000);
    wreg(5'h1F, 16'h1234);
    rreg(5'h1F, 16'h0000);
    ct = '{'{16'h0E, 16'h0004, 16'h0004}, '{16'h0E, 16'h000F, 16'h0008}, '{16'h10, 16'h0014, 16'h0010},
      '{16'h10, 16'hFFEC, 16'hFFF0}, '{16'h09, 16'hFF38, 16'hFF9C}, '{16'h09, 16'h4E20, 16'h2710},
      '{16'h0D, 16'h0009, 16'h0008}, '{16'h01, 16'hFC18, 16'hFCE1}, '{16'h11, 16'h0010, 16'h0008},
      '{16'h0F, 16'h0010, 16'h0008}};
    for (int i = 0; i < 10; i++) begin
      wreg(ct[i][0][4:0], ct[i][1]);
      rreg(ct[i][0][4:0], ct[i][2]);
    end
    wreg(5'h00, 16'h0005);
    tb = '{16'hFFC0, 16'h0040, 16'h0024, 16'hFFDC};
    for (int i = 1; i < 5; i++) rreg(5'(i), tb[i - 1]);
    wreg(5'h01, 16'h8000);
    rreg(5'h01, 16'hCE01);
    wreg(5'h03, 16'h7FFF);
    rreg(5'h03, 16'h257F);
    wreg(5'h00, 16'h0004);
    rreg(5'h05, 16'hFFFC);
    for (int i = 9; i < 18; i++) wreg(5'(i), (i == 14) ? 16'h0008 : 16'h0000);
    pxl(px(16'h0000, 8'h10), 32'h104050FE);
    pxl(px(16'h000A, 8'h10), 32'h10405000);
    pxl(px(16'h0004, 8'h10), 32'h10405000);
    pxl(px(16'h0003, 8'h10), 32'h104050FE);
    wreg(5'h11, 16'h0008);
    wreg(5'h05, 16'h0000);
    pxl(px(16'hFFFE, 8'h10), 32'hFF8080FE);
    pxl(px(16'h0001, 8'h10), 32'h104050FE);
    wreg(5'h05, 16'hFFFC);
    wreg(5'h0D, 16'h0008);
    pget(px(16'h0003, 8'h10), w);
    rchk(16'(w[31:24] > 8'hE0), 16'h0001);
    rchk({8'h00, w[7:0]}, 16'h00FE);
    wreg(5'h0D, 16'h0000);
    wreg(5'h11, 16'h0000);
    tb = '{16'hFCE1, 16'h031F, 16'h031F, 16'hFCE1};
    for (int i = 1; i < 5; i++) wreg(5'(i), tb[i - 1]);
    wreg(5'h00, 16'h0002);
    wreg(5'h0A, 16'h0320);
    pxl(px(16'h031F, 8'h10), 32'hFF808000);
    pxl(px(16'h0306, 8'h10), 32'hFF80803F);
    pxl(px(16'h02ED, 8'h10), 32'hFF80807F);
    pxl(px(16'h02BB, 8'h10), 32'hFF8080FF);
    wreg(5'h00, 16'h0000);
    pxl(px(16'h02ED, 8'h10), 32'h104050FE);
    wreg(5'h09, 16'h0320);
    pxl(px(16'h02ED, 8'h10), 32'h1040507E);
    wreg(5'h00, 16'h0002);
    cl = '{'{8, 8, 0, 32'hFFF080FF}, '{8, 8, 1, 32'hFFCFCFFF}, '{8, 8, 2, 32'hFF80F0FF},
      '{8, 8, 16, 32'hFFF080FF}, '{4, 0, 0, 32'h808080FF}, '{0, 0, 0, 32'h008080FF}};
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) wreg(5'(14 + j), cl[i][j][15:0]);
      pxl(px(16'h0064, 8'h10), cl[i][3]);
    end
    wreg(5'h00, 16'h0000);
    stl <= 1'b1;
    for (int i = 0; i < 16; i++) push(px(16'h0000, 8'(i)));
    @(negedge MCLK_IN);
    rchk({15'h0000, rdy}, 16'h0000);
    rreg(5'h12, 16'h0010);
    @(posedge MCLK_IN);
    stl <= 1'b0;
    for (int i = 0; i < 60 && u_sink.got.size() < 16; i++) @(posedge MCLK_IN);
    rchk(16'(u_sink.got.size()), 16'h0010);
    for (int i = 0; i < 16; i++) pchk(u_sink.got.pop_front(), {8'(i), 24'h4050FE});
    rreg(5'h12, 16'h0000);
    report_and_stop();
  end
endmodule
